// >>> bct_map.vh
// Register offsets, field positions, reset values and timing counts of the byte timer
`ifndef BCT_MAP_VH
`define BCT_MAP_VH

// ****************************************************************
// Register offsets (expanded register bank)
// ****************************************************************
`define BCT_OFS_PRIMARY_CTRL     8'h00
`define BCT_OFS_SECONDARY_CTRL   8'h01
`define BCT_OFS_RELOAD_HIGH      8'h02
`define BCT_OFS_RELOAD_LOW       8'h03
`define BCT_OFS_CAPTURE_POS      8'h04
`define BCT_OFS_CAPTURE_NEG      8'h05

// ****************************************************************
// Primary control fields
// ****************************************************************
`define BCT_P_ENABLE             7
`define BCT_P_SINGLE_PASS        6
`define BCT_P_TIMEOUT            5
`define BCT_P_CLKSEL_HI          4
`define BCT_P_CLKSEL_LO          3
`define BCT_P_INT_MASK           1
`define BCT_P_PIN_SELECT         0

// ****************************************************************
// Secondary control fields
// ****************************************************************
`define BCT_S_DEMOD_MODE         6
`define BCT_S_EDGE_HI            5
`define BCT_S_EDGE_LO            4
`define BCT_S_INIT_LEVEL         1
`define BCT_S_NEG_FLAG           1
`define BCT_S_POS_FLAG           0

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define BCT_RST_BYTE             8'h00
`define BCT_RELOAD_RST           8'hFF
`define BCT_COUNT_ONE            8'h01
`define BCT_COUNT_FULL           8'hFF
`define BCT_EDGE_RISE            2'b00
`define BCT_EDGE_FALL            2'b01
`define BCT_EDGE_BOTH            2'b10

`endif

// >>> bct_prescaler.v
// Timer clock prescaler: one-cycle tick at a selectable division of the system clock
`timescale 1ns/1ps

module bct_prescaler
#(
	parameter DIV_W = 4
)
(
	input  wire       clk_sys_i,
	input  wire       reset_i,
	input  wire       run_i,
	input  wire [1:0] clk_sel_i,
	output reg        tick_o
);

	reg [DIV_W-1:0] div_q;
	reg [DIV_W-1:0] div_d;
	reg             tick_d;

	// ****************************************************************
	// Divider: tick every 2, 4, 8 or 16 system clocks
	// ****************************************************************
	always @*
	begin
		div_d  = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
		tick_d = 1'b0;
		case (clk_sel_i)
			2'd0: tick_d = (div_q[0] == 1'b1);
			2'd1: tick_d = (div_q[1:0] == 2'b11);
			2'd2: tick_d = (div_q[2:0] == 3'b111);
			default: tick_d = (div_q[3:0] == 4'b1111);
		endcase
		if (!run_i)
		begin
			tick_d = 1'b0;
		end
	end

	// Free-running divider, so the first tick after enable is unaligned
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			div_q  <= {DIV_W{1'b0}};
			tick_o <= 1'b0;
		end
		else
		begin
			div_q  <= div_d;
			tick_o <= tick_d;
		end
	end

endmodule // bct_prescaler

// >>> bct_edge_detect.v
// Edge detector for the demodulation input with polarity selection
`timescale 1ns/1ps

`include "bct_map.vh"

module bct_edge_detect
(
	input  wire       clk_sys_i,
	input  wire       reset_i,
	input  wire       sig_i,
	input  wire [1:0] edge_sel_i,
	output reg        rise_o,
	output reg        fall_o
);

	reg prev_q;

	// ****************************************************************
	// Qualified rising and falling edge pulses
	// ****************************************************************
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			prev_q <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
		end
		else
		begin
			prev_q <= sig_i;
			rise_o <= sig_i & ~prev_q & (edge_sel_i != `BCT_EDGE_FALL);
			fall_o <= ~sig_i & prev_q & (edge_sel_i != `BCT_EDGE_RISE);
		end
	end

endmodule // bct_edge_detect

// >>> bct_byte_timer.v
// Byte timer: 8-bit down counter with dual reload, pin output and demodulation capture
`timescale 1ns/1ps

`include "bct_map.vh"

module bct_byte_timer
(
	input  wire       clk_sys_i,
	input  wire       reset_i,
	input  wire       stop_recovery_i,
	input  wire [7:0] reg_addr_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	input  wire [7:0] reg_wdata_i,
	output reg  [7:0] reg_rdata_o,
	input  wire       port_latch_i,
	input  wire       demod_in_i,
	output reg        shared_port_pin_o,
	output reg        timer_output_level_o,
	output reg        timeout_irq_o
);

	// ****************************************************************
	// States
	// ****************************************************************
	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_LOAD  = 3'd1;
	localparam [2:0] ST_COUNT = 3'd2;
	localparam [2:0] ST_DWAIT = 3'd3;
	localparam [2:0] ST_DCNT  = 3'd4;

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg       enable_q;
	reg       single_pass_q;
	reg       timeout_q;
	reg [1:0] clk_sel_q;
	reg       int_mask_q;
	reg       pin_select_q;
	reg       demod_mode_q;
	reg [1:0] edge_sel_q;
	reg       init_level_q;
	reg       pos_flag_q;
	reg       neg_flag_q;
	reg [7:0] reload_high_value_q;
	reg [7:0] reload_low_value_q;
	reg [7:0] capture_pos_q;
	reg [7:0] capture_neg_q;
	reg [7:0] count_q;
	reg [2:0] state_q;
	reg       first_tc_q;
	reg [7:0] count_d;
	reg [2:0] state_d;
	reg       first_tc_d;
	reg       level_d;
	reg       tc_event;
	reg       stop_event;
	reg       start_event;
	wire      tick;
	wire      rise;
	wire      fall;
	wire      wr_primary;
	wire      wr_secondary;
	wire      running;

	// Selects the reload register that matches an output level
	function [7:0] reload_for(input level, input [7:0] low_value, input [7:0] high_value);
		reload_for = level ? high_value : low_value;
	endfunction

	assign wr_primary   = reg_wr_i && (reg_addr_i == `BCT_OFS_PRIMARY_CTRL);
	assign wr_secondary = reg_wr_i && (reg_addr_i == `BCT_OFS_SECONDARY_CTRL);
	assign running      = (state_q != ST_IDLE);

	// ****************************************************************
	// Tick source and edge detection
	// ****************************************************************
	bct_prescaler #(.DIV_W(4)) u_prescaler (
		.clk_sys_i  (clk_sys_i),
		.reset_i    (reset_i),
		.run_i      (running),
		.clk_sel_i  (clk_sel_q),
		.tick_o     (tick)
	);

	bct_edge_detect u_edge (
		.clk_sys_i  (clk_sys_i),
		.reset_i    (reset_i),
		.sig_i      (demod_in_i),
		.edge_sel_i (edge_sel_q),
		.rise_o     (rise),
		.fall_o     (fall)
	);

	// ****************************************************************
	// Counter state machine
	// ****************************************************************
	always @*
	begin
		count_d     = count_q;
		state_d     = state_q;
		first_tc_d  = first_tc_q;
		level_d     = timer_output_level_o;
		tc_event    = 1'b0;
		stop_event  = 1'b0;
		start_event = wr_primary && reg_wdata_i[`BCT_P_ENABLE] && !enable_q;
		if (wr_primary && !reg_wdata_i[`BCT_P_ENABLE])
			state_d = ST_IDLE;
		else if (start_event)
		begin
			first_tc_d = 1'b1;
			if (demod_mode_q)
				state_d = ST_DWAIT;
			else
			begin
				level_d = init_level_q;
				state_d = ST_LOAD;
			end
		end
		else
		begin
			case (state_q)
				ST_LOAD:
				begin
					if (tick)
					begin
						count_d = reload_for(timer_output_level_o, reload_low_value_q,
							reload_high_value_q);
						state_d = ST_COUNT;
					end
				end
				ST_COUNT:
				begin
					if (tick)
					begin
						count_d = count_q - `BCT_COUNT_ONE;
						if (count_q == `BCT_COUNT_ONE)
						begin
							level_d    = ~timer_output_level_o;
							first_tc_d = 1'b0;
							if (single_pass_q)
							begin
								tc_event   = 1'b1;
								stop_event = 1'b1;
								state_d    = ST_IDLE;
							end
							else
							begin
								tc_event = !first_tc_q;
								state_d  = ST_LOAD;
							end
						end
					end
				end
				ST_DWAIT:
				begin
					if (rise || fall)
					begin
						count_d = reload_for(1'b0, reload_low_value_q, reload_high_value_q);
						state_d = ST_DCNT;
					end
				end
				ST_DCNT:
				begin
					if (tick)
						count_d = count_q - `BCT_COUNT_ONE;
				end
				default:
					state_d = ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Counter, state and output level
	// ****************************************************************
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			count_q              <= `BCT_RST_BYTE;
			state_q              <= ST_IDLE;
			first_tc_q           <= 1'b0;
			timer_output_level_o <= 1'b0;
		end
		else if (stop_recovery_i)
		begin
			state_q    <= ST_IDLE;
			first_tc_q <= 1'b0;
		end
		else
		begin
			count_q              <= count_d;
			state_q              <= state_d;
			first_tc_q           <= first_tc_d;
			timer_output_level_o <= level_d;
		end
	end

	// ****************************************************************
	// Primary control register
	// ****************************************************************
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			enable_q      <= 1'b0;
			single_pass_q <= 1'b0;
			timeout_q     <= 1'b0;
			clk_sel_q     <= 2'b00;
			int_mask_q    <= 1'b0;
			pin_select_q  <= 1'b0;
		end
		else if (stop_recovery_i)
		begin
			enable_q     <= 1'b0;
			timeout_q    <= 1'b0;
			pin_select_q <= 1'b0;
		end
		else
		begin
			if (wr_primary)
			begin
				enable_q      <= reg_wdata_i[`BCT_P_ENABLE];
				single_pass_q <= reg_wdata_i[`BCT_P_SINGLE_PASS];
				clk_sel_q     <= reg_wdata_i[`BCT_P_CLKSEL_HI:`BCT_P_CLKSEL_LO];
				int_mask_q    <= reg_wdata_i[`BCT_P_INT_MASK];
				pin_select_q  <= reg_wdata_i[`BCT_P_PIN_SELECT];
			end
			else if (stop_event)
				enable_q <= 1'b0;
			// Set wins over a simultaneous write-one clear
			if (tc_event)
				timeout_q <= 1'b1;
			else if (wr_primary && reg_wdata_i[`BCT_P_TIMEOUT])
				timeout_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Secondary control and capture registers
	// ****************************************************************
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			demod_mode_q  <= 1'b0;
			edge_sel_q    <= `BCT_EDGE_RISE;
			init_level_q  <= 1'b0;
			pos_flag_q    <= 1'b0;
			neg_flag_q    <= 1'b0;
			capture_pos_q <= `BCT_RST_BYTE;
			capture_neg_q <= `BCT_RST_BYTE;
		end
		else
		begin
			if (wr_secondary)
			begin
				demod_mode_q <= reg_wdata_i[`BCT_S_DEMOD_MODE];
				edge_sel_q   <= reg_wdata_i[`BCT_S_EDGE_HI:`BCT_S_EDGE_LO];
				init_level_q <= reg_wdata_i[`BCT_S_INIT_LEVEL];
			end
			// Complemented count capture, set wins over clear
			if (state_q == ST_DCNT && rise)
			begin
				capture_pos_q <= ~count_q;
				pos_flag_q    <= 1'b1;
			end
			else if (wr_secondary && demod_mode_q && reg_wdata_i[`BCT_S_POS_FLAG])
				pos_flag_q <= 1'b0;
			if (state_q == ST_DCNT && fall)
			begin
				capture_neg_q <= ~count_q;
				neg_flag_q    <= 1'b1;
			end
			else if (wr_secondary && demod_mode_q && reg_wdata_i[`BCT_S_NEG_FLAG])
				neg_flag_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Reload registers
	// ****************************************************************
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			reload_high_value_q <= `BCT_RELOAD_RST;
			reload_low_value_q  <= `BCT_RELOAD_RST;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == `BCT_OFS_RELOAD_HIGH)
				reload_high_value_q <= reg_wdata_i;
			else if (reg_addr_i == `BCT_OFS_RELOAD_LOW)
				reload_low_value_q <= reg_wdata_i;
		end
	end

	// ****************************************************************
	// Pin, interrupt and read data
	// ****************************************************************
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			shared_port_pin_o <= 1'b0;
			timeout_irq_o     <= 1'b0;
			reg_rdata_o       <= `BCT_RST_BYTE;
		end
		else
		begin
			shared_port_pin_o <= pin_select_q ? timer_output_level_o : port_latch_i;
			timeout_irq_o     <= timeout_q & int_mask_q;
			if (reg_rd_i)
			begin
				if (reg_addr_i == `BCT_OFS_PRIMARY_CTRL)
					reg_rdata_o <= {enable_q, single_pass_q, timeout_q, clk_sel_q, 1'b0,
						int_mask_q, pin_select_q};
				else if (reg_addr_i == `BCT_OFS_SECONDARY_CTRL)
					reg_rdata_o <= {1'b0, demod_mode_q, edge_sel_q, 2'b00,
						demod_mode_q ? neg_flag_q : init_level_q, pos_flag_q};
				else if (reg_addr_i == `BCT_OFS_RELOAD_HIGH)
					reg_rdata_o <= reload_high_value_q;
				else if (reg_addr_i == `BCT_OFS_RELOAD_LOW)
					reg_rdata_o <= reload_low_value_q;
				else if (reg_addr_i == `BCT_OFS_CAPTURE_POS)
					reg_rdata_o <= capture_pos_q;
				else if (reg_addr_i == `BCT_OFS_CAPTURE_NEG)
					reg_rdata_o <= capture_neg_q;
				else
					reg_rdata_o <= `BCT_RST_BYTE;
			end
		end
	end

endmodule // bct_byte_timer

// >>> bct_byte_timer_asserts.sv
// Concurrent checks of the byte timer at its ports
`timescale 1ns/1ps

module bct_checker
(
	input wire       clk_sys_i,
	input wire       reset_i,
	input wire       stop_recovery_i,
	input wire [7:0] reg_addr_i,
	input wire       reg_wr_i,
	input wire       reg_rd_i,
	input wire [7:0] reg_wdata_i,
	input wire [7:0] reg_rdata_o,
	input wire       port_latch_i,
	input wire       shared_port_pin_o,
	input wire       timer_output_level_o,
	input wire       timeout_irq_o
);
	// ****************************************************************
	// Shadows of mask and pin select, taken from control writes
	// ****************************************************************
	reg  mask_q;
	reg  sel_q;
	wire ctl_wr = reg_wr_i && (reg_addr_i == 8'h00);
	wire clr_wr = ctl_wr && reg_wdata_i[5];

	// Stop recovery drops the select but keeps the mask
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			mask_q <= 1'b0;
			sel_q  <= 1'b0;
		end
		else
		begin
			mask_q <= ctl_wr ? reg_wdata_i[1] : mask_q;
			sel_q  <= stop_recovery_i ? 1'b0 : (ctl_wr ? reg_wdata_i[0] : sel_q);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);

	a_pin_port: assert property (!sel_q |=> shared_port_pin_o == $past(port_latch_i))
		else $error("Shared pin does not follow the port latch");
	a_pin_timer: assert property (sel_q |=> shared_port_pin_o == $past(timer_output_level_o))
		else $error("Shared pin does not follow the timer output");
	a_irq_masked: assert property (!mask_q |=> !timeout_irq_o)
		else $error("Interrupt raised while masked");
	a_irq_rise_mask: assert property ($rose(timeout_irq_o) |-> $past(mask_q))
		else $error("Interrupt rose without the mask set");
	a_irq_holds: assert property (timeout_irq_o && mask_q && !clr_wr && !$past(clr_wr)
		&& !stop_recovery_i && !$past(stop_recovery_i) |=> timeout_irq_o)
		else $error("Timeout flag dropped without a clearing write");
	a_mask_readback: assert property (reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[1] == $past(mask_q))
		else $error("Mask bit reads back wrong");
	a_sel_readback: assert property (reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[0] == $past(sel_q))
		else $error("Pin select bit reads back wrong");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h05 |=> reg_rdata_o == 8'h00)
		else $error("Unmapped read is not zero");
	a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("Read data changed without a read");

	c_irq_rise: cover property ($rose(timeout_irq_o));
	c_pin_toggle: cover property (sel_q && $changed(timer_output_level_o));
	c_stop_keep: cover property (stop_recovery_i && mask_q);
endmodule // bct_checker

bind bct_byte_timer bct_checker u_chk
(
	.clk_sys_i(clk_sys_i), .reset_i(reset_i), .stop_recovery_i(stop_recovery_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .port_latch_i(port_latch_i),
	.shared_port_pin_o(shared_port_pin_o), .timer_output_level_o(timer_output_level_o),
	.timeout_irq_o(timeout_irq_o)
);

// >>> bct_tb.sv
// Self-checking testbench of the byte timer
`timescale 1ns/1ps

module tb;
	typedef struct packed {logic wr; logic [7:0] a; logic [7:0] w; logic [7:0] e;} bct_row_t;

	logic       clk_sys_i, reset_i, stop_recovery_i, reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
	logic       port_latch_i, demod_in_i, shared_port_pin_o, timer_output_level_o, timeout_irq_o;
	int         n_errors, checked, n;
	bct_row_t   rows [13];
	logic [7:0] dcfg [3] = '{8'h40, 8'h50, 8'h60};
	int         dpos [3] = '{20, 20, 20};
	int         dneg [3] = '{0, 20, 30};
	logic [7:0] dflg [3] = '{8'h41, 8'h52, 8'h63};

	bct_byte_timer dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .stop_recovery_i(stop_recovery_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .port_latch_i(port_latch_i), .demod_in_i(demod_in_i),
		.shared_port_pin_o(shared_port_pin_o), .timer_output_level_o(timer_output_level_o),
		.timeout_irq_o(timeout_irq_o));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rng(input string nm, input logic [7:0] v, input int e);
		logic [7:0] lo;
		logic [7:0] hi;
		lo = (e > 2) ? 8'(e - 2) : 8'h00;
		hi = 8'(e + 2);
		chk(nm, (v >= lo && v <= hi) ? 8'h01 : 8'h00, 8'h01);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i    <= 1'b0;
	endtask

	// Register read, result left in rv
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i   <= 1'b0;
		#1 rv = reg_rdata_o;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk($sformatf("reg_%h", a), rv, e);
	endtask

	// Enable write, then let the initial level land
	task automatic en(input logic [7:0] d);
		wr(8'h00, d);
		repeat (2) @(negedge clk_sys_i);
	endtask

	// Cycles until the timer output changes, capped at max
	task automatic wait_tog(input int max, output int cnt);
		logic old;
		old = timer_output_level_o;
		cnt = 0;
		do
		begin
			@(negedge clk_sys_i);
			cnt++;
		end
		while (timer_output_level_o === old && cnt < max);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ****************************************************************
	// Clock, watchdog and test sequence
	// ****************************************************************
	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// Run should end near 0.13 ms
	initial
	begin
		#1_000_000;
		n_errors++;
		stop_test;
	end

	initial
	begin
		{reset_i, stop_recovery_i, reg_wr_i, reg_rd_i, demod_in_i, port_latch_i} = 6'b100001;
		{reg_addr_i, reg_wdata_i, n_errors, checked} = '0;
		rows = '{'{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h01, 8'h00, 8'h00}, '{1'b0, 8'h02, 8'h00, 8'hFF},
			'{1'b0, 8'h03, 8'h00, 8'hFF}, '{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h05, 8'h00, 8'h00},
			'{1'b0, 8'h09, 8'h00, 8'h00}, '{1'b1, 8'h03, 8'h05, 8'h05}, '{1'b1, 8'h02, 8'h07, 8'h07},
			'{1'b1, 8'h04, 8'h5A, 8'h00}, '{1'b1, 8'h09, 8'h33, 8'h00}, '{1'b1, 8'h00, 8'h03, 8'h03},
			'{1'b1, 8'h01, 8'h02, 8'h02}};
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk("pin", {7'h00, shared_port_pin_o}, 8'h01);
		chk("level", {6'h00, timer_output_level_o, timeout_irq_o}, 8'h00);
		@(posedge clk_sys_i);
		port_latch_i <= 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk("pin_low", {7'h00, shared_port_pin_o}, 8'h00);
		@(posedge clk_sys_i);
		port_latch_i <= 1'b1;
		$display("test reset done");
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].w);
			rc(rows[i].a, rows[i].e);
		end
		@(posedge clk_sys_i);
		stop_recovery_i <= 1'b1;
		@(posedge clk_sys_i);
		stop_recovery_i <= 1'b0;
		rc(8'h00, 8'h02);
		$display("test registers done");
		// Single pass from the low reload, no start without enable
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h43);
		wait_tog(30, n);
		chk("no_start", n[7:0], 8'd30);
		en(8'hC3);
		chk("init", {7'h00, timer_output_level_o}, 8'h00);
		wait_tog(40, n);
		chk("sp_delay", (n >= 4 && n <= 14) ? 8'h01 : 8'h00, 8'h01);
		repeat (2) @(negedge clk_sys_i);
		chk("sp_irq", {7'h00, timeout_irq_o}, 8'h01);
		chk("sp_pin", {7'h00, shared_port_pin_o}, 8'h01);
		rc(8'h00, 8'h63);
		wr(8'h00, 8'h43);
		rc(8'h00, 8'h63);
		wr(8'h00, 8'h63);
		rc(8'h00, 8'h43);
		$display("test single pass done");
		// Zero in the high reload wraps through FFh
		wr(8'h02, 8'h00);
		wr(8'h01, 8'h02);
		en(8'hC3);
		wait_tog(600, n);
		chk("wrap", (n >= 500 && n <= 520) ? 8'h01 : 8'h00, 8'h01);
		wr(8'h00, 8'h63);
		$display("test wrap done");
		// Repeat mode with a reload rewrite in mid-run
		wr(8'h01, 8'h00);
		wr(8'h03, 8'h03);
		wr(8'h02, 8'h05);
		en(8'h83);
		wait_tog(40, n);
		wait_tog(40, n);
		chk("high_half", n[7:0], 8'd12);
		chk("first_irq", {7'h00, timeout_irq_o}, 8'h00);
		repeat (2) @(negedge clk_sys_i);
		chk("later_irq", {7'h00, timeout_irq_o}, 8'h01);
		wr(8'h02, 8'h07);
		wait_tog(40, n);
		wait_tog(40, n);
		chk("new_high", n[7:0], 8'd16);
		wr(8'h00, 8'h03);
		wr(8'h00, 8'h23);
		rc(8'h00, 8'h03);
		$display("test repeat done");
		// Every clock select, mask off
		wr(8'h02, 8'h03);
		for (int s = 0; s < 4; s++)
		begin
			en({3'b100, 2'(s), 3'b000});
			wait_tog(200, n);
			wait_tog(200, n);
			chk("clk_sel", n[7:0], 8'(8 << s));
			wr(8'h00, 8'h00);
			wr(8'h00, 8'h20);
			chk("no_irq", {7'h00, timeout_irq_o}, 8'h00);
		end
		$display("test clock select done");
		// Initial level high lands on enable
		wr(8'h01, 8'h02);
		en(8'h80);
		chk("init_high", {7'h00, timer_output_level_o}, 8'h01);
		wr(8'h00, 8'h00);
		$display("test initial level done");
		// Demodulation in every edge polarity
		wr(8'h02, 8'hFF);
		wr(8'h03, 8'hFF);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h00, 8'h00);
			wr(8'h01, dcfg[i] | 8'h03);
			en(8'h80);
			repeat (4)
			begin
				repeat (20) @(posedge clk_sys_i);
				demod_in_i <= ~demod_in_i;
			end
			repeat (5) @(posedge clk_sys_i);
			rd(8'h04);
			rng("capture_pos", rv, dpos[i]);
			rd(8'h05);
			rng("capture_neg", rv, dneg[i]);
			rc(8'h01, dflg[i]);
		end
		rc(8'h01, 8'h63);
		$display("test demodulation done");
		stop_test;
	end
endmodule // tb
